// file: vpap_top.sv
`timescale 1ns/1ps
`default_nettype none
module vpap_top
   import vpap_pkg::*;
#(
   parameter int NUM_PIPES = 2,
   parameter int PIPE_W = 1
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CE,
   input wire logic [15:0] IO_ADDR,
   input wire logic IO_WR,
   input wire logic IO_RD,
   input wire logic [7:0] IO_WDATA,
   output logic [7:0] IO_RDATA,
   input wire logic ATTR_FLIP_CLR,
   input wire logic [PIPE_W-1:0] HOST_PIPE_SEL,
   input wire logic [PIPE_W-1:0] PIX_PIPE,
   input wire logic PIX_INDEXED,
   input wire logic [7:0] PIX_IN,
   input wire logic [5:0] ATTR_ENTRY_BITS,
   input wire logic MODE_ALT_P54,
   output logic [7:0] PAL_INDEX,
   output logic [23:0] PIX_RGB
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic attr_data_phase;
      logic [4:0] attr_idx;
      logic [7:0] csel;
      logic [7:0] mask;
      logic [7:0] rd_idx;
      logic [7:0] wr_idx;
      vpap_byte_e rd_byte;
      vpap_byte_e wr_byte;
      logic [7:0] buf_red;
      logic [7:0] buf_green;
      logic [1:0] status;
      logic [7:0] rdata;
      logic [7:0] pal_index;
      logic [PIPE_W-1:0] pix_pipe;
      logic [23:0] pix_rgb;
   } vpap_state_s;

   vpap_state_s st_ff;
   vpap_state_s nxt_st;
   logic [23:0] pal_mem [NUM_PIPES*POSITIONS];
   logic commit;
   logic [23:0] rd_word;
   logic [7:0] lookup_idx;
   logic [7:0] rd_sel_byte;
   logic wr_hit;
   logic rd_hit;

   assign rd_word = pal_mem[{HOST_PIPE_SEL, st_ff.rd_idx}];

   always_comb begin
      case (st_ff.rd_byte)
         VPAP_RED: rd_sel_byte = rd_word[23:16];
         VPAP_GREEN: rd_sel_byte = rd_word[15:8];
         VPAP_BLUE: rd_sel_byte = rd_word[7:0];
         default: rd_sel_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_st = st_ff;
      commit = 1'b0;
      wr_hit = CE && IO_WR;
      rd_hit = CE && IO_RD;
      lookup_idx = 8'h00;
      if (ATTR_FLIP_CLR) begin
         nxt_st.attr_data_phase = 1'b0;
      end
      if (wr_hit && IO_ADDR == PORT_ATTR_WR) begin
         nxt_st.attr_data_phase = !st_ff.attr_data_phase;
         if (!st_ff.attr_data_phase) begin
            nxt_st.attr_idx = IO_WDATA[4:0];
         end else if (st_ff.attr_idx == ATTR_IDX_CSEL) begin
            nxt_st.csel = {4'h0, IO_WDATA[3:0]};
         end
      end
      if (wr_hit && IO_ADDR == PORT_MASK) begin
         nxt_st.mask = IO_WDATA;
      end
      if (wr_hit && IO_ADDR == PORT_RD_POS) begin
         nxt_st.rd_idx = IO_WDATA;
         nxt_st.rd_byte = VPAP_RED;
         nxt_st.wr_byte = VPAP_RED;
         nxt_st.status = STAT_RD_IDX;
      end
      if (wr_hit && IO_ADDR == PORT_WR_POS) begin
         nxt_st.wr_idx = IO_WDATA;
         nxt_st.wr_byte = VPAP_RED;
         nxt_st.status = STAT_WR_IDX;
      end
      if (wr_hit && IO_ADDR == PORT_DATA) begin
         case (st_ff.wr_byte)
            VPAP_RED: begin
               nxt_st.buf_red = IO_WDATA;
               nxt_st.wr_byte = VPAP_GREEN;
            end
            VPAP_GREEN: begin
               nxt_st.buf_green = IO_WDATA;
               nxt_st.wr_byte = VPAP_BLUE;
            end
            VPAP_BLUE: begin
               commit = 1'b1;
               nxt_st.wr_byte = VPAP_RED;
               nxt_st.wr_idx = st_ff.wr_idx + 8'h01;
            end
            default: nxt_st.wr_byte = VPAP_RED;
         endcase
      end
      if (rd_hit) begin
         case (IO_ADDR)
            PORT_ATTR_RD: nxt_st.rdata = (st_ff.attr_idx == ATTR_IDX_CSEL) ? st_ff.csel : 8'h00;
            PORT_MASK: nxt_st.rdata = st_ff.mask;
            PORT_RD_POS: nxt_st.rdata = {6'h00, st_ff.status};
            PORT_WR_POS: nxt_st.rdata = st_ff.wr_idx;
            PORT_DATA: nxt_st.rdata = rd_sel_byte;
            default: nxt_st.rdata = 8'h00;
         endcase
      end
      if (rd_hit && IO_ADDR == PORT_DATA) begin
         case (st_ff.rd_byte)
            VPAP_RED: nxt_st.rd_byte = VPAP_GREEN;
            VPAP_GREEN: nxt_st.rd_byte = VPAP_BLUE;
            VPAP_BLUE: begin
               nxt_st.rd_byte = VPAP_RED;
               nxt_st.rd_idx = st_ff.rd_idx + 8'h01;
            end
            default: nxt_st.rd_byte = VPAP_RED;
         endcase
      end
      if (PIX_INDEXED) begin
         lookup_idx = PIX_IN & st_ff.mask;
      end else begin
         lookup_idx[7:6] = st_ff.csel[CSEL_HI_LSB +: 2];
         lookup_idx[5:4] = MODE_ALT_P54 ? st_ff.csel[CSEL_ALT_LSB +: 2] : ATTR_ENTRY_BITS[5:4];
         lookup_idx[3:0] = ATTR_ENTRY_BITS[3:0];
      end
      nxt_st.pal_index = lookup_idx;
      nxt_st.pix_pipe = PIX_PIPE;
      // second stage looks up what the first stage indexed
      nxt_st.pix_rgb = pal_mem[{st_ff.pix_pipe, st_ff.pal_index}];
      if (!CE) begin
         nxt_st = st_ff;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_ff <= '{attr_data_phase: 1'b0, attr_idx: 5'h00, csel: CSEL_RESET,
                    mask: MASK_RESET, rd_idx: IDX_RESET, wr_idx: IDX_RESET,
                    rd_byte: VPAP_RED, wr_byte: VPAP_RED, buf_red: 8'h00,
                    buf_green: 8'h00, status: STAT_WR_IDX, rdata: 8'h00,
                    pal_index: 8'h00, pix_pipe: '0, pix_rgb: 24'h000000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge CLK) begin
      if (commit) begin
         pal_mem[{HOST_PIPE_SEL, st_ff.wr_idx}] <= {st_ff.buf_red, st_ff.buf_green, IO_WDATA};
      end
   end

   assign IO_RDATA = st_ff.rdata;
   assign PAL_INDEX = st_ff.pal_index;
   assign PIX_RGB = st_ff.pix_rgb;

   ////////////////////////////////////////////////////////////////////////////////
   sequence data_wr_s;
      CE && IO_WR && IO_ADDR == PORT_DATA;
   endsequence
   sequence data_rd_s;
      CE && IO_RD && IO_ADDR == PORT_DATA;
   endsequence

   mask_and_index_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      CE && PIX_INDEXED |=> PAL_INDEX == ($past(PIX_IN) & $past(st_ff.mask)))
      else $error("indexed pixel not masked");
   csel_upper_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      CE && !PIX_INDEXED |=> PAL_INDEX[7:6] == $past(st_ff.csel[3:2]))
      else $error("upper index bits not from colour select");
   csel_alt_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      CE && !PIX_INDEXED && MODE_ALT_P54 |=> PAL_INDEX[5:4] == $past(st_ff.csel[1:0]))
      else $error("alternate bits not used");
   wr_index_incr_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      data_wr_s ##0 (st_ff.wr_byte == VPAP_BLUE) |=> st_ff.wr_idx == $past(st_ff.wr_idx) + 8'h01)
      else $error("write index did not advance");
   rd_index_incr_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      data_rd_s ##1 data_rd_s ##1 data_rd_s |=> st_ff.rd_idx == $past(st_ff.rd_idx, 3) + 8'h01
      || st_ff.rd_byte != VPAP_RED)
      else $error("read index did not advance after three reads");
   commit_word_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      data_wr_s ##0 (st_ff.wr_byte == VPAP_BLUE)
      |=> pal_mem[{$past(HOST_PIPE_SEL), $past(st_ff.wr_idx)}]
      == {$past(st_ff.buf_red), $past(st_ff.buf_green), $past(IO_WDATA)})
      else $error("third byte did not store the buffered entry");
   rd_load_abort_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      CE && IO_WR && IO_ADDR == PORT_RD_POS |=> st_ff.wr_byte == VPAP_RED && st_ff.rd_byte == VPAP_RED)
      else $error("read index load did not abort write");
   status_code_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      CE && IO_WR && IO_ADDR == PORT_WR_POS ##1 CE && IO_RD && IO_ADDR == PORT_RD_POS
      |=> IO_RDATA == 8'h00)
      else $error("status does not show write index");
   mask_readback_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      CE && IO_WR && IO_ADDR == PORT_MASK ##1 CE && IO_RD && IO_ADDR == PORT_MASK
      |=> IO_RDATA == $past(IO_WDATA, 2))
      else $error("mask readback wrong");
endmodule : vpap_top
`default_nettype wire

// file: vpap_pkg.sv
// Operation
// - colour-select bits 3:2 form palette index bits 7:6 for attribute pixels
// - colour-select bits 1:0 replace entry bits 5:4 when mode bit 7 set
// - colour select at attribute index 14h, written via 3C0h, read via 3C1h
// - one palette per display pipe, host access routed by pipe select
// - 256 positions of three bytes, reached only through data port 3C9h
// - separate read index at 3C7h and write index at 3C8h
// - data reads return red, then green, then blue
// - read index increments after third byte read
// - written bytes are taken in order red, green, blue
// - written bytes are buffered and committed only after the third byte
// - write index increments after third byte written
// - indexed mode: pixel value ANDed with pixel mask gives palette index
// - mask bit 0 forces index bit 0, mask bit 1 passes pixel bit
// - status reports last index written: 00 write index, 11 read index
// - loading read index discards an unfinished write sequence
package vpap_pkg;
   localparam logic [15:0] PORT_ATTR_WR = 16'h03c0;
   localparam logic [15:0] PORT_ATTR_RD = 16'h03c1;
   localparam logic [15:0] PORT_MASK = 16'h03c6;
   localparam logic [15:0] PORT_RD_POS = 16'h03c7;
   localparam logic [15:0] PORT_WR_POS = 16'h03c8;
   localparam logic [15:0] PORT_DATA = 16'h03c9;
   localparam logic [4:0] ATTR_IDX_CSEL = 5'h14;
   localparam logic [7:0] CSEL_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'hff;
   localparam logic [7:0] IDX_RESET = 8'h00;
   localparam logic [1:0] STAT_WR_IDX = 2'h0;
   localparam logic [1:0] STAT_RD_IDX = 2'h3;
   localparam int CSEL_HI_LSB = 2;
   localparam int CSEL_ALT_LSB = 0;
   localparam int POSITIONS = 256;
   typedef enum logic [1:0] {
      VPAP_RED = 2'b00,
      VPAP_GREEN = 2'b01,
      VPAP_BLUE = 2'b10
   } vpap_byte_e;
endpackage : vpap_pkg

// file: vpap_host.sv
`timescale 1ns/1ps
`default_nettype none
module vpap_host (
   input wire logic clk,
   output logic [15:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata
);
   logic [7:0] rd_q;
   initial begin
      io_addr = 16'h0000;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   ////////////////////////////////////////
   // byte-wide port access
   task automatic op(input logic w, input logic [15:0] a, input logic [7:0] d);
      io_addr = a;
      io_wr = w;
      io_rd = !w;
      io_wdata = d;
      @(posedge clk);
      #1;
      rd_q = io_rdata;
   endtask : op
   // released lines show stale inverted values, never the last ones
   task automatic idle(input int n);
      if (io_wr || io_rd) begin
         io_wr = 1'b0;
         io_rd = 1'b0;
         io_addr = ~io_addr;
         io_wdata = ~io_wdata;
      end
      repeat (n) @(posedge clk);
      if (n > 0) #1;
   endtask : idle
endmodule : vpap_host
`default_nettype wire

// file: vga_palette_access_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module vga_palette_access_port_tb
   import vpap_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n;
   logic ce;
   logic flip;
   logic [0:0] hsel;
   logic [0:0] ppipe;
   logic pidx;
   logic alt;
   logic [7:0] pin;
   logic [5:0] aent;
   logic [15:0] addr;
   logic wr;
   logic rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] pal_index;
   logic [23:0] pix_rgb;
   logic [23:0] pal [2][256];
   logic [7:0] mask = MASK_RESET;
   logic [7:0] csel = CSEL_RESET;
   logic [7:0] wri = IDX_RESET;
   logic [7:0] rdi = IDX_RESET;
   logic [1:0] stat = STAT_WR_IDX;
   logic [7:0] wbuf [3];
   logic [15:0] ports [5] = '{PORT_ATTR_RD, 16'h03c5, PORT_MASK, PORT_RD_POS, PORT_WR_POS};
   logic [7:0] r;
   logic [7:0] ei;
   logic [23:0] pe;
   int rb = 0;
   int wb = 0;
   int aidx = 0;
   int af = 0;
   int i;
   int p;
   int errors = 0;
   int checks_done = 0;
   int seed = 32'h2c74;
   always #4 clk = ~clk;
   vpap_top #(.NUM_PIPES(2), .PIPE_W(1)) dut (.CLK(clk), .ARST_N(arst_n), .CE(ce),
      .IO_ADDR(addr), .IO_WR(wr), .IO_RD(rd), .IO_WDATA(wdata), .IO_RDATA(rdata),
      .ATTR_FLIP_CLR(flip), .HOST_PIPE_SEL(hsel), .PIX_PIPE(ppipe), .PIX_INDEXED(pidx),
      .PIX_IN(pin), .ATTR_ENTRY_BITS(aent), .MODE_ALT_P54(alt), .PAL_INDEX(pal_index),
      .PIX_RGB(pix_rgb));
   vpap_host host (.clk(clk), .io_addr(addr), .io_wr(wr), .io_rd(rd), .io_wdata(wdata),
      .io_rdata(rdata));
   ////////////////////////////////////////
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      logic [7:0] e;
      e = 8'h00;
      host.op(w, a, d);
      if (w) begin
         case (a)
            PORT_ATTR_WR: begin
               if (af == 0) aidx = d[4:0];
               else if (aidx == 20) csel = {4'h0, d[3:0]};
               af = 1 - af;
            end
            PORT_MASK: mask = d;
            PORT_RD_POS: begin
               rdi = d;
               rb = 0;
               wb = 0;
               stat = STAT_RD_IDX;
            end
            PORT_WR_POS: begin
               wri = d;
               wb = 0;
               stat = STAT_WR_IDX;
            end
            PORT_DATA: begin
               wbuf[wb] = d;
               wb++;
               if (wb == 3) begin
                  pal[hsel][wri] = {wbuf[0], wbuf[1], wbuf[2]};
                  wri++;
                  wb = 0;
               end
            end
            default: ;
         endcase
      end else begin
         case (a)
            PORT_ATTR_RD: e = (aidx == 20) ? csel : 8'h00;
            PORT_MASK: e = mask;
            PORT_RD_POS: e = {6'h00, stat};
            PORT_WR_POS: e = wri;
            PORT_DATA: begin
               e = pal[hsel][rdi][23 - 8 * rb -: 8];
               rb++;
               if (rb == 3) begin
                  rb = 0;
                  rdi++;
               end
            end
            default: e = 8'h00;
         endcase
         `CHK(host.rd_q, e)
      end
      if ($random(seed) % 4 == 0) host.idle(1);
   endtask : acc
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      complete_run;
   end
   ////////////////////////////////////////
   initial begin
      arst_n = 1'b0;
      ce = 1'b1;
      flip = 1'b0;
      hsel = 1'b0;
      ppipe = 1'b0;
      pidx = 1'b0;
      alt = 1'b0;
      pin = 8'h00;
      aent = 6'h00;
      repeat (5) @(posedge clk);
      #1;
      arst_n = 1'b1;
      acc(1'b1, 16'h03c5, 8'h5a);
      for (i = 1; i < 5; i++) acc(1'b0, ports[i], 8'h00);
      // status after each index load, mask read as the next access after its write, sometimes after an idle cycle
      repeat (4) begin
         acc(1'b1, PORT_RD_POS, 8'h00);
         acc(1'b0, PORT_RD_POS, 8'h00);
         acc(1'b1, PORT_WR_POS, 8'h00);
         acc(1'b0, PORT_RD_POS, 8'h00);
         acc(1'b1, PORT_MASK, 8'($random(seed)));
         acc(1'b0, PORT_MASK, 8'h00);
      end
      $display("test regs done");
      acc(1'b1, PORT_ATTR_WR, 8'h03);
      acc(1'b1, PORT_ATTR_WR, 8'hff);
      acc(1'b1, PORT_ATTR_WR, 8'h05);
      host.idle(0);
      flip = 1'b1;
      host.idle(1);
      flip = 1'b0;
      af = 0;
      acc(1'b1, PORT_ATTR_WR, {3'h0, ATTR_IDX_CSEL});
      acc(1'b1, PORT_ATTR_WR, 8'($random(seed)));
      acc(1'b0, PORT_ATTR_RD, 8'h00);
      host.idle(0);
      ce = 1'b0;
      host.op(1'b1, PORT_MASK, ~mask);
      host.idle(0);
      ce = 1'b1;
      acc(1'b0, PORT_MASK, 8'h00);
      $display("test attr done");
      for (p = 0; p < 2; p++) begin
         hsel = 1'(p);
         acc(1'b1, PORT_WR_POS, 8'hfa);
         for (i = 0; i < 768; i++) acc(1'b1, PORT_DATA, 8'($random(seed)));
      end
      acc(1'b1, PORT_WR_POS, 8'h05);
      acc(1'b1, PORT_DATA, 8'h11);
      acc(1'b1, PORT_DATA, 8'h22);
      acc(1'b1, PORT_RD_POS, 8'h04);
      repeat (6) acc(1'b0, PORT_DATA, 8'h00);
      $display("test fill done");
      for (i = 0; i < 800; i++) begin
         r = 8'($random(seed));
         case ({$random(seed)} % 10)
            0, 1, 2: acc(1'b1, PORT_DATA, r);
            3, 4: acc(1'b0, PORT_DATA, 8'h00);
            5: acc(1'b1, PORT_RD_POS, r);
            6: acc(1'b1, PORT_WR_POS, r);
            7: acc(1'b1, PORT_MASK, r);
            8: acc(1'b0, ports[r % 5], 8'h00);
            default: hsel = r[0];
         endcase
      end
      $display("test random done");
      host.idle(0);
      for (p = 0; p < 2; p++) begin
         ppipe = 1'(p);
         for (i = 0; i < 200; i++) begin
            {pidx, alt, aent} = 8'($random(seed));
            pin = 8'($random(seed));
            ei = pidx ? (pin & mask) : {csel[3:2], alt ? csel[1:0] : aent[5:4], aent[3:0]};
            @(posedge clk);
            #1;
            `CHK(pal_index, ei)
            if (i > 0) `CHK(pix_rgb, pe)
            pe = pal[ppipe][ei];
         end
      end
      $display("test pixel done");
      complete_run;
   end
endmodule : vga_palette_access_port_tb
`default_nettype wire
